/* File: dmx_pkg.sv */
package dmx_pkg;
  // register byte offsets on the control bus
  localparam logic [7:0] OFF_AUX = 8'h00;
  localparam logic [7:0] OFF_STATUS_WORD = 8'h04;
  localparam logic [7:0] OFF_HI_PORT = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  // auxiliary_control_reg fields
  localparam int STRETCH_BIT = 5;
  localparam int SIZE_LSB = 2;
  localparam int EXT_SEL_BIT = 1;
  localparam int LATCH_CTRL_BIT = 0;
  localparam int DSPEED_BIT = 6;
  localparam logic [7:0] AUX_RST = 8'h14;
  localparam logic [7:0] STATUS_WORD_RST = 8'h00;
  localparam logic [7:0] HI_PORT_RST = 8'hFF;
  // program_status_word bank select
  localparam int BANK_LO_BIT = 3;
  localparam int BANK_HI_BIT = 4;
  // internal map
  localparam logic [7:0] LOWER_TOP = 8'h7F;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [7:0] HI_PORT_SFR = 8'hA0;
  localparam int EXP_RAM_BYTES = 2048;
  // bus cycle in cpu clock periods; idle latch strobe spacing in oscillator cycles
  localparam logic [4:0] PH_STROBE = 5'h02;
  localparam logic [4:0] STROBE_STD = 5'h03;
  localparam logic [4:0] STROBE_STRETCH = 5'h0F;
  localparam logic [2:0] ALE_IDLE_OSC = 3'h6;
  typedef enum logic [2:0] {
    MD_DIRECT, MD_INDIRECT, MD_REG, MD_BIT, MD_MOVX_RI, MD_MOVX_DPTR
  } dmx_mode_e;
  typedef enum logic [2:0] {
    SEG_LOWER, SEG_UPPER, SEG_SFR, SEG_EXP_RAM, SEG_EXT
  } dmx_seg_e;
endpackage

/* File: dmx_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dmx_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // core access port
  input wire logic req_valid,
  input wire dmx_pkg::dmx_mode_e req_mode,
  input wire logic [15:0] req_addr,
  input wire logic req_we,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  output dmx_pkg::dmx_seg_e resp_seg,
  // function register space
  output logic sfr_rd,
  output logic sfr_wr,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // external bus pins
  input wire logic [7:0] low_addr_data_port_i,
  output logic [7:0] low_addr_data_port_o,
  output logic low_addr_data_port_oe_n,
  output logic [7:0] high_addr_port,
  output logic ale,
  output logic rd_n,
  output logic wr_n
);
  typedef enum logic [1:0] {ST_IDLE, ST_SFR, ST_EXT} dmx_state_e;
  dmx_state_e st_r;
  // contents undefined at power-up; software clears them
  // no ram init
  logic [7:0] iram [0:255];
  logic [7:0] exp_ram [0:dmx_pkg::EXP_RAM_BYTES-1];
  logic [7:0] aux_r, status_word_r, hi_port_r;
  logic awf_r, wf_r, ext_we_r, div_r, ri_r;
  logic [7:0] awa_r, wd_r, ad_s1_r, ad_s2_r, ext_wd_r;
  logic [15:0] xaddr_r;
  logic [4:0] ph_r;
  logic [2:0] ale_cnt_r;
  logic [7:0] ibyte;
  logic [11:0] exp_lim;
  logic [15:0] xaddr;
  logic take, tick, exp_hit, is_sfr, ext_go;
  logic [4:0] strobe_w, ph_last, strobe_last;

  always_comb begin
    case (aux_r[dmx_pkg::SIZE_LSB +: 3])
      3'h0: exp_lim = 12'h100;
      3'h1: exp_lim = 12'h200;
      3'h2: exp_lim = 12'h300;
      3'h3: exp_lim = 12'h400;
      3'h4: exp_lim = 12'h700;
      default: exp_lim = 12'h800;
    endcase
  end

  always_comb begin
    ibyte = req_addr[7:0];
    is_sfr = 1'b0;
    if (req_mode == dmx_pkg::MD_REG) begin
      ibyte = {3'h0, status_word_r[dmx_pkg::BANK_HI_BIT], status_word_r[dmx_pkg::BANK_LO_BIT],
        req_addr[2:0]};
    end
    if (req_mode == dmx_pkg::MD_BIT) begin
      ibyte = req_addr[7] ? {req_addr[7:3], 3'h0} : dmx_pkg::BIT_BASE + {4'h0, req_addr[6:3]};
      is_sfr = req_addr[7];
    end
    // direct high half is function space, indirect is ram
    if (req_mode == dmx_pkg::MD_DIRECT) begin
      is_sfr = req_addr[7:0] > dmx_pkg::LOWER_TOP;
    end
  end

  // register-pointer moves take port-two register as high byte
  assign xaddr = (req_mode == dmx_pkg::MD_MOVX_RI) ? {hi_port_r, req_addr[7:0]} : req_addr;
  assign exp_hit = !aux_r[dmx_pkg::EXT_SEL_BIT] && ({4'h0, exp_lim} > xaddr);
  // any move outside expanded ram becomes a bus cycle
  assign ext_go = (req_mode == dmx_pkg::MD_MOVX_RI || req_mode == dmx_pkg::MD_MOVX_DPTR)
    && !exp_hit;
  assign take = req_valid && req_ready;
  // cpu period is two oscillator cycles unless double speed
  assign tick = aux_r[dmx_pkg::DSPEED_BIT] | div_r;
  assign strobe_w = aux_r[dmx_pkg::STRETCH_BIT] ? dmx_pkg::STROBE_STRETCH : dmx_pkg::STROBE_STD;
  assign strobe_last = dmx_pkg::PH_STROBE + strobe_w - 5'h01;
  // six periods with the standard strobe, three outside the strobe
  assign ph_last = strobe_last + 5'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 1'b0;
      ale_cnt_r <= 3'h0;
    end else begin
      div_r <= !div_r;
      ale_cnt_r <= (ale_cnt_r == dmx_pkg::ALE_IDLE_OSC - 3'h1) ? 3'h0 : ale_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_rdata <= 8'h00;
      resp_seg <= dmx_pkg::SEG_LOWER;
      sfr_rd <= 1'b0;
      sfr_wr <= 1'b0;
      sfr_addr <= 8'h00;
      sfr_wdata <= 8'h00;
      ph_r <= 5'h00;
      xaddr_r <= 16'h0000;
      ext_we_r <= 1'b0;
      ext_wd_r <= 8'h00;
      ri_r <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      sfr_rd <= 1'b0;
      sfr_wr <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (take) begin
            req_ready <= 1'b0;
            if (ext_go) begin
              st_r <= ST_EXT;
              ph_r <= 5'h00;
              xaddr_r <= xaddr;
              ext_we_r <= req_we;
              ext_wd_r <= req_wdata;
              ri_r <= req_mode == dmx_pkg::MD_MOVX_RI;
              resp_seg <= dmx_pkg::SEG_EXT;
            end else if (req_mode == dmx_pkg::MD_MOVX_RI || req_mode == dmx_pkg::MD_MOVX_DPTR) begin
              resp_valid <= 1'b1;
              resp_rdata <= exp_ram[xaddr[10:0]];
              resp_seg <= dmx_pkg::SEG_EXP_RAM;
            end else if (is_sfr) begin
              st_r <= ST_SFR;
              sfr_rd <= !req_we;
              sfr_wr <= req_we;
              sfr_addr <= ibyte;
              sfr_wdata <= req_wdata;
              resp_seg <= dmx_pkg::SEG_SFR;
            end else begin
              resp_valid <= 1'b1;
              resp_rdata <= (req_mode == dmx_pkg::MD_BIT)
                ? {7'h00, iram[ibyte][req_addr[2:0]]} : iram[ibyte];
              resp_seg <= ibyte[7] ? dmx_pkg::SEG_UPPER : dmx_pkg::SEG_LOWER;
            end
          end
        end
        ST_SFR: begin
          st_r <= ST_IDLE;
          resp_valid <= 1'b1;
          resp_rdata <= (sfr_addr == dmx_pkg::HI_PORT_SFR) ? hi_port_r : sfr_rdata;
        end
        ST_EXT: begin
          // sync lags two edges, so the strobe's end shows as the cycle closes
          if (tick && ph_r == ph_last && !ext_we_r) begin
            resp_rdata <= ad_s2_r;
          end
          if (tick) begin
            ph_r <= ph_r + 5'h01;
            if (ph_r == ph_last) begin
              st_r <= ST_IDLE;
              resp_valid <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (take && !is_sfr && !ext_go && req_we) begin
      if (req_mode == dmx_pkg::MD_MOVX_RI || req_mode == dmx_pkg::MD_MOVX_DPTR) begin
        exp_ram[xaddr[10:0]] <= req_wdata;
      end else if (req_mode == dmx_pkg::MD_BIT) begin
        iram[ibyte][req_addr[2:0]] <= req_wdata[0];
      end else begin
        iram[ibyte] <= req_wdata;
      end
    end
  end

  // pin side: two-stage sync on port zero input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ad_s1_r <= 8'h00;
      ad_s2_r <= 8'h00;
    end else begin
      ad_s1_r <= low_addr_data_port_i;
      ad_s2_r <= ad_s1_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      low_addr_data_port_o <= 8'hFF;
      low_addr_data_port_oe_n <= 1'b1;
      high_addr_port <= dmx_pkg::HI_PORT_RST;
    end else begin
      // latch strobe on bus cycle or free-running
      ale <= (st_r == ST_EXT) ? (ph_r == 5'h00)
        : (!aux_r[dmx_pkg::LATCH_CTRL_BIT] && ale_cnt_r == 3'h0);
      // address then data on port zero, high byte on port two
      low_addr_data_port_o <= (ph_r < dmx_pkg::PH_STROBE) ? xaddr_r[7:0] : ext_wd_r;
      // read releases port zero after the address phase
      low_addr_data_port_oe_n <= !(st_r == ST_EXT && (ph_r == 5'h00 || ext_we_r));
      // register-pointer move shows the port-two register
      high_addr_port <= (st_r == ST_EXT && !ri_r) ? xaddr_r[15:8] : hi_port_r;
      rd_n <= !(st_r == ST_EXT && !ext_we_r && ph_r >= dmx_pkg::PH_STROBE && ph_r <= strobe_last);
      wr_n <= !(st_r == ST_EXT && ext_we_r && ph_r >= dmx_pkg::PH_STROBE && ph_r <= strobe_last);
    end
  end

  // axi4-lite slave: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awf_r <= 1'b0;
      wf_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 8'h00;
      s_bvalid <= 1'b0;
      s_bresp <= 2'b00;
      aux_r <= dmx_pkg::AUX_RST;
      status_word_r <= dmx_pkg::STATUS_WORD_RST;
      hi_port_r <= dmx_pkg::HI_PORT_RST;
    end else begin
      if (s_awvalid && s_awready) begin
        awf_r <= 1'b1;
        awa_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        wf_r <= 1'b1;
        wd_r <= s_wstrb[0] ? s_wdata[7:0] : 8'h00;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (awf_r && wf_r && !s_bvalid) begin
        awf_r <= 1'b0;
        wf_r <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= 2'b00;
        unique case (awa_r)
          dmx_pkg::OFF_AUX: aux_r <= wd_r;
          dmx_pkg::OFF_STATUS_WORD: status_word_r <= wd_r;
          dmx_pkg::OFF_HI_PORT: hi_port_r <= wd_r;
          dmx_pkg::OFF_STAT: s_bresp <= 2'b10;
          default: s_bresp <= 2'b10;
        endcase
      end
    end
  end
  assign s_awready = !awf_r && !s_bvalid;
  assign s_wready = !wf_r && !s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'b00;
    end else if (s_rvalid) begin
      s_rvalid <= !s_rready;
    end else if (s_arvalid) begin
      s_rvalid <= 1'b1;
      s_rresp <= 2'b00;
      unique case (s_araddr)
        dmx_pkg::OFF_AUX: s_rdata <= {24'h00_0000, aux_r};
        dmx_pkg::OFF_STATUS_WORD: s_rdata <= {24'h00_0000, status_word_r};
        dmx_pkg::OFF_HI_PORT: s_rdata <= {24'h00_0000, hi_port_r};
        dmx_pkg::OFF_STAT: s_rdata <= {27'h000_0000, ph_r != 5'h00, 1'b0, st_r, !req_ready};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= 2'b10;
        end
      endcase
    end
  end
  assign s_arready = !s_rvalid;

  a_rd_strobe_std: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(rd_n) && !aux_r[dmx_pkg::STRETCH_BIT] && aux_r[dmx_pkg::DSPEED_BIT]
    |-> !rd_n [*3] ##1 rd_n) else $error("read strobe not three periods");
  a_wr_strobe_std: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(wr_n) && !aux_r[dmx_pkg::STRETCH_BIT] && aux_r[dmx_pkg::DSPEED_BIT]
    |-> !wr_n [*3] ##1 wr_n) else $error("write strobe not three periods");
  a_cycle_len: assert property (@(posedge aclk) disable iff (!aresetn)
    take && ext_go && aux_r[dmx_pkg::DSPEED_BIT] && !aux_r[dmx_pkg::STRETCH_BIT]
    |-> ##7 resp_valid) else $error("bus cycle not six periods");
  a_ale_first: assert property (@(posedge aclk) disable iff (!aresetn)
    take && ext_go |-> ##2 ale && !low_addr_data_port_oe_n) else $error("no latch strobe");
  a_read_release: assert property (@(posedge aclk) disable iff (!aresetn)
    !rd_n |-> low_addr_data_port_oe_n) else $error("port zero driven in read");
  a_exp_ram_local: assert property (@(posedge aclk) disable iff (!aresetn)
    take && req_mode == dmx_pkg::MD_MOVX_DPTR && !aux_r[dmx_pkg::EXT_SEL_BIT]
    && req_addr < 16'h0100 |=> resp_valid && resp_seg == dmx_pkg::SEG_EXP_RAM)
    else $error("expanded ram miss");
  a_ext_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    take && req_mode == dmx_pkg::MD_MOVX_DPTR && aux_r[dmx_pkg::EXT_SEL_BIT]
    |=> st_r == ST_EXT) else $error("external select ignored");
  a_direct_sfr: assert property (@(posedge aclk) disable iff (!aresetn)
    take && req_mode == dmx_pkg::MD_DIRECT && req_addr[7] |=> sfr_rd || sfr_wr)
    else $error("direct high not function space");
  a_indirect_ram: assert property (@(posedge aclk) disable iff (!aresetn)
    take && req_mode == dmx_pkg::MD_INDIRECT && req_addr[7]
    |=> resp_valid && resp_seg == dmx_pkg::SEG_UPPER) else $error("upper ram missed");
  c_ext_read: cover property (@(posedge aclk) disable iff (!aresetn) $fell(rd_n));
  c_ext_write: cover property (@(posedge aclk) disable iff (!aresetn) $fell(wr_n));
  c_stretch: cover property (@(posedge aclk) !rd_n && aux_r[dmx_pkg::STRETCH_BIT]);
  c_bit_op: cover property (@(posedge aclk) take && req_mode == dmx_pkg::MD_BIT);
endmodule
`default_nettype wire

/* File: dmx_ext_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module dmx_ext_mem (
  // clock
  input wire logic aclk,
  // bus pins
  input wire logic [7:0] bus,
  input wire logic [7:0] hi,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  // model control and view
  input wire logic slow,
  output logic [7:0] drv,
  output logic [15:0] last_addr
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo_r;
  logic [7:0] prev_r = 8'hA5;
  logic [4:0] cnt_r = 5'h0;
  always_ff @(posedge aclk) begin
    if (ale) begin
      lo_r <= bus;
      last_addr <= {hi, bus};
    end
  end
  always_ff @(posedge aclk) begin
    if (!wr_n) begin
      mem[{hi, lo_r}] <= bus;
    end
  end
  // idle lines toggle so a stale value never reads as data
  always_ff @(posedge aclk) begin
    prev_r <= drv;
    cnt_r <= rd_n ? 5'h0 : cnt_r + 5'h1;
  end
  assign drv = (!rd_n && (!slow || cnt_r >= 5'h8)) ? mem[{hi, lo_r}] : ~prev_r;
endmodule
`default_nettype wire

/* File: dmx_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, req_wdata = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
  logic s_rready = 1'b0, req_valid = 1'b0, req_we = 1'b0, slow = 1'b0;
  dmx_pkg::dmx_mode_e req_mode = dmx_pkg::MD_DIRECT;
  logic [15:0] req_addr = 16'h0000;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, req_ready, resp_valid;
  logic sfr_rd, sfr_wr, oe_n, ale, rd_n, wr_n;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [7:0] resp_rdata, sfr_addr, sfr_wdata, lo_o, hi_bus, drv, pin, rd;
  logic [17:0] sfr_last = 18'h0_0000;
  dmx_pkg::dmx_seg_e resp_seg;
  logic [2:0] sg;
  logic [15:0] last_addr;
  logic [15:0] sz_tab [8] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0700, 16'h0800,
    16'h0800, 16'h0800};
  int n_fail = 0, comparisons = 0, cyc = 0, rd_cnt = 0, wr_cnt = 0, ale_cnt = 0;
  assign pin = oe_n ? drv : lo_o;
  always #5 aclk = ~aclk;
  dmx_top uut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .req_valid(req_valid),
    .req_mode(req_mode), .req_addr(req_addr), .req_we(req_we), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .resp_seg(resp_seg), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(8'h5A), .low_addr_data_port_i(pin),
    .low_addr_data_port_o(lo_o), .low_addr_data_port_oe_n(oe_n), .high_addr_port(hi_bus),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
  dmx_ext_mem ext_mem (.aclk(aclk), .bus(pin), .hi(hi_bus), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .slow(slow), .drv(drv), .last_addr(last_addr));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (!rd_n) rd_cnt++;
    if (!wr_n) wr_cnt++;
    if (ale) ale_cnt++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  always @(posedge aclk) begin
    if (aresetn && !rd_n) chk("oe_n in read", 32'h1, {31'h0, oe_n});
  end
  always @(posedge aclk) begin
    if (sfr_rd || sfr_wr) sfr_last <= {sfr_rd, sfr_wr, sfr_addr, sfr_wdata};
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_awready) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w && s_wready) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_bvalid);
    s_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_rvalid);
    s_rready <= 1'b0;
    chk("rdata", e, s_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_rresp});
  endtask
  task automatic core(input dmx_pkg::dmx_mode_e m, input logic [15:0] a, input logic we,
    input logic [7:0] wd);
    @(negedge aclk);
    rd_cnt = 0;
    wr_cnt = 0;
    @(posedge aclk);
    req_valid <= 1'b1;
    req_mode <= m;
    req_addr <= a;
    req_we <= we;
    req_wdata <= wd;
    do @(posedge aclk); while (!req_ready);
    req_valid <= 1'b0;
    do @(posedge aclk); while (!resp_valid);
    rd = resp_rdata;
    sg = resp_seg;
  endtask
  task automatic t_ale;
    repeat (6) @(negedge aclk);
    ale_cnt = 0;
    repeat (60) @(negedge aclk);
    chk("ale free", 32'd10, ale_cnt);
    axi_wr(dmx_pkg::OFF_AUX, 32'h0000_0015, 2'h0);
    @(negedge aclk);
    ale_cnt = 0;
    repeat (60) @(negedge aclk);
    chk("ale gated", 32'd0, ale_cnt);
  endtask
  task automatic t_regs;
    axi_rd(dmx_pkg::OFF_STATUS_WORD, 32'h0000_0000, 2'h0);
    axi_rd(dmx_pkg::OFF_HI_PORT, 32'h0000_00FF, 2'h0);
    axi_rd(dmx_pkg::OFF_STAT, 32'h0000_0000, 2'h0);
    axi_rd(8'h10, 32'h0000_0000, 2'h2);
    axi_wr(dmx_pkg::OFF_STAT, 32'h0000_0000, 2'h2);
  endtask
  task automatic t_lower;
    core(dmx_pkg::MD_DIRECT, 16'h007F, 1'b1, 8'hC3);
    core(dmx_pkg::MD_INDIRECT, 16'h007F, 1'b0, 8'h00);
    chk("lower", {24'h0, 8'hC3}, {24'h0, rd});
    chk("seg lower", 32'(dmx_pkg::SEG_LOWER), {29'h0, sg});
  endtask
  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      axi_wr(dmx_pkg::OFF_STATUS_WORD, 32'(b) << 3, 2'h0);
      core(dmx_pkg::MD_REG, 16'h0005, 1'b1, 8'h60 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      core(dmx_pkg::MD_DIRECT, 16'(b * 8 + 5), 1'b0, 8'h00);
      chk("bank reg", 32'h60 + 32'(b), {24'h0, rd});
    end
  endtask
  task automatic t_bits;
    core(dmx_pkg::MD_DIRECT, 16'h0021, 1'b1, 8'h00);
    core(dmx_pkg::MD_BIT, 16'h000A, 1'b1, 8'h01);
    core(dmx_pkg::MD_DIRECT, 16'h0021, 1'b0, 8'h00);
    chk("bit byte", 32'h0000_0004, {24'h0, rd});
    core(dmx_pkg::MD_BIT, 16'h000A, 1'b0, 8'h00);
    chk("bit read", 32'h1, {31'h0, rd[0]});
  endtask
  task automatic t_upper;
    core(dmx_pkg::MD_INDIRECT, 16'h0090, 1'b1, 8'h77);
    core(dmx_pkg::MD_DIRECT, 16'h0090, 1'b0, 8'h00);
    chk("sfr data", 32'h0000_005A, {24'h0, rd});
    chk("seg sfr", 32'(dmx_pkg::SEG_SFR), {29'h0, sg});
    chk("sfr read strobe", 32'h0002_9000, {14'h0, sfr_last});
    core(dmx_pkg::MD_DIRECT, 16'h0095, 1'b1, 8'h3A);
    chk("sfr write strobe", 32'h0001_953A, {14'h0, sfr_last});
    core(dmx_pkg::MD_BIT, 16'h00A5, 1'b0, 8'h00);
    chk("bit sfr byte", 32'h0002_A000, {14'h0, sfr_last});
    chk("bit sfr data", 32'h0000_00FF, {24'h0, rd});
    core(dmx_pkg::MD_INDIRECT, 16'h0090, 1'b0, 8'h00);
    chk("upper", 32'h0000_0077, {24'h0, rd});
    chk("seg upper", 32'(dmx_pkg::SEG_UPPER), {29'h0, sg});
  endtask
  task automatic t_exp_ram;
    for (int c = 0; c < 8; c++) begin
      axi_wr(dmx_pkg::OFF_AUX, 32'h0000_0041 | (32'(c) << 2), 2'h0);
      core(dmx_pkg::MD_MOVX_DPTR, sz_tab[c] - 16'h1, 1'b1, 8'h11);
      chk("seg in size", 32'(dmx_pkg::SEG_EXP_RAM), {29'h0, sg});
      core(dmx_pkg::MD_MOVX_DPTR, sz_tab[c], 1'b1, 8'h22);
      chk("seg past size", 32'(dmx_pkg::SEG_EXT), {29'h0, sg});
    end
    core(dmx_pkg::MD_MOVX_DPTR, 16'h07FF, 1'b0, 8'h00);
    chk("exp ram data", 32'h0000_0011, {24'h0, rd});
  endtask
  task automatic t_ext;
    for (int k = 0; k < 4; k++) begin
      axi_wr(dmx_pkg::OFF_AUX, 32'h0000_0017 | (32'(k) << 5), 2'h0);
      slow <= k[0];
      core(dmx_pkg::MD_MOVX_DPTR, 16'h0123 + 16'(k), 1'b1, 8'h3C + 8'(k));
      chk("wr width", (k[0] ? 15 : 3) * (k[1] ? 1 : 2), wr_cnt);
      chk("ext addr", 32'h0123 + 32'(k), {16'h0, last_addr});
      core(dmx_pkg::MD_MOVX_DPTR, 16'h0123 + 16'(k), 1'b0, 8'h00);
      chk("rd width", (k[0] ? 15 : 3) * (k[1] ? 1 : 2), rd_cnt);
      chk("ext data", 32'h3C + 32'(k), {24'h0, rd});
      chk("seg ext", 32'(dmx_pkg::SEG_EXT), {29'h0, sg});
    end
  endtask
  task automatic t_ri;
    axi_wr(dmx_pkg::OFF_HI_PORT, 32'h0000_0012, 2'h0);
    core(dmx_pkg::MD_MOVX_RI, 16'h0034, 1'b1, 8'h5E);
    chk("ri addr", 32'h0000_1234, {16'h0, last_addr});
    core(dmx_pkg::MD_MOVX_RI, 16'h0034, 1'b0, 8'h00);
    chk("ri data", 32'h0000_005E, {24'h0, rd});
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(dmx_pkg::OFF_AUX, 32'h0000_0014, 2'h0);
    t_ale();
    t_regs();
    t_lower();
    t_banks();
    t_bits();
    t_upper();
    t_exp_ram();
    t_ext();
    t_ri();
    final_report();
  end
endmodule
`default_nettype wire
